// ==== design/uslc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - after break error the flag stays set; re-arm break reception
// - set break trigger only while power and receive enable are one
// - change bit order and inversion only with both enables cleared
// - stop: enables off then power; start: power then enables
// - in LIN use both parity bits are held at zero
// - in LIN use transmit status must be all zero before a write
// - write next byte only after buffer-full flag reads zero
// - reinitialise only after completion and shifting flag reads zero
// - read the receive buffer after every reception, errors included
// - read receive error status before the receive buffer
module uslc_ctrl #(
	parameter int RD_LAT = uslc_pkg::DEV_RD_LAT
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	output logic                   irq,
	output uslc_pkg::uslc_dev_s    dev,
	input  wire logic [7:0]        dev_rdata,
	input  wire uslc_pkg::uslc_evt_s dev_evt
);
	import uslc_pkg::*;

	localparam int          WAIT_N   = RD_LAT + SYNC_STAGES;
	localparam logic [3:0]  WAIT_CNT = 4'(WAIT_N);

	typedef struct packed {
		uslc_state_e      fsm;
		uslc_state_e      ret;
		logic [3:0]       wait_cnt;
		uslc_dev_s        bus;
		logic [7:0]       rd_s1;
		logic [7:0]       rd_s2;
		uslc_evt_s        ev_s1;
		uslc_evt_s        ev_s2;
		uslc_evt_s        ev_s3;
		logic [5:0]       ctrl;
		logic             running;
		logic             armed;
		logic             start_p;
		logic             stop_p;
		logic             arm_p;
		logic             cfg_p;
		logic             rx_p;
		logic             tx_full;
		logic [7:0]       tx_byte;
		logic [7:0]       rx_byte;
		logic [7:0]       rx_err;
		logic [7:0]       tx_stat;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic [15:0]      n_sent;
		logic [15:0]      n_done;
	} uslc_core_s;

	uslc_core_s  st;
	uslc_core_s  next_st;
	uslc_req_s   req;
	logic [31:0] rd_word;
	uslc_evt_s   ev;
	logic        lin;
	logic        busy;
	logic [1:0]  par;
	logic [7:0]  mode_byte;
	logic [7:0]  ext_byte;

	uslc_ahb_slv u_slv (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.req       (req),
		.rd_word   (rd_word)
	);

	// ctrl: [0] lin, [1] dir, [2] invert, [3] auto rearm, [5:4] parity
	assign lin  = st.ctrl[0];
	assign par  = lin ? 2'h0 : st.ctrl[5:4];
	assign busy = (st.fsm != ST_IDLE);
	assign ev   = st.ev_s2 & ~st.ev_s3;
	assign dev  = st.bus;
	assign irq  = |(st.irq_stat & st.irq_mask);

	// device control bytes; the trigger is only set on an arm command or an auto re-arm
	always_comb begin
		mode_byte                        = 8'h00;
		mode_byte[MODE_PAR_LO +: 2]      = par;
		ext_byte                         = 8'h00;
		ext_byte[EXT_DIR]                = st.ctrl[1];
		ext_byte[EXT_INVERT]             = st.ctrl[2];
	end

	// register read mux, side effects handled in the next process
	always_comb begin
		rd_word = 32'h0;
		unique case (req.rd_idx)
			REG_CTRL:     rd_word[5:0] = st.ctrl;
			REG_CMD:      rd_word = 32'h0;
			REG_TXDATA:   rd_word[0] = st.tx_full;
			REG_STATUS:   rd_word = {8'h00, st.rx_err, st.tx_stat,
				3'h0, st.rx_p, st.tx_full, st.armed, st.running, busy};
			REG_RXDATA:   rd_word[15:0] = {st.rx_err, st.rx_byte};
			REG_IRQ_STAT: rd_word[IRQ_W-1:0] = st.irq_stat;
			REG_IRQ_MASK: rd_word[IRQ_W-1:0] = st.irq_mask;
			REG_COUNT:    rd_word = {st.n_done, st.n_sent};
		endcase
	end

	always_comb begin
		next_st       = st;
		next_st.bus.wr = 1'b0;
		next_st.bus.rd = 1'b0;
		// pin synchronisers; stage one is read only by stage two
		next_st.rd_s1 = dev_rdata;
		next_st.rd_s2 = st.rd_s1;
		next_st.ev_s1 = dev_evt;
		next_st.ev_s2 = st.ev_s1;
		next_st.ev_s3 = st.ev_s2;

		// read of irq status clears it; a same-cycle event still wins below
		if (req.rd && (req.rd_idx == REG_IRQ_STAT)) begin
			next_st.irq_stat = '0;
		end

		// software writes; a command is refused while a sequence is in flight
		if (req.wr) begin
			unique case (req.wr_idx)
				REG_CTRL: begin
					if (!st.running) begin
						next_st.ctrl = req.wdata[5:0];
					end else begin
						next_st.ctrl[3] = req.wdata[3];
						next_st.irq_stat[IRQ_REFUSED] = 1'b1;
					end
				end
				REG_CMD: begin
					if (busy || st.start_p || st.stop_p || st.arm_p || st.cfg_p) begin
						next_st.irq_stat[IRQ_REFUSED] = 1'b1;
					end else begin
						next_st.start_p = req.wdata[CMD_START] & ~st.running;
						next_st.stop_p  = req.wdata[CMD_STOP] & st.running;
						next_st.arm_p   = req.wdata[CMD_ARM] & st.running;
						next_st.cfg_p   = req.wdata[CMD_CFG] & ~st.running;
					end
				end
				REG_TXDATA: begin
					if (st.tx_full || !st.running) begin
						next_st.irq_stat[IRQ_REFUSED] = 1'b1;
					end else begin
						next_st.tx_full = 1'b1;
						next_st.tx_byte = req.wdata[7:0];
					end
				end
				REG_IRQ_MASK: next_st.irq_mask = req.wdata[IRQ_W-1:0];
				default: ;
			endcase
		end

		// device events
		if (ev.rx_done) begin
			next_st.rx_p = 1'b1;
		end
		if (ev.tx_done) begin
			next_st.n_done = st.n_done + 16'h1;
			// a second completion before the first is serviced
			if (st.irq_stat[IRQ_TX_DONE] && !(req.rd && (req.rd_idx == REG_IRQ_STAT))) begin
				next_st.irq_stat[IRQ_TX_OVR] = 1'b1;
			end
			next_st.irq_stat[IRQ_TX_DONE] = 1'b1;
		end
		if (ev.brk_ok) begin
			next_st.armed = 1'b0;
			next_st.irq_stat[IRQ_BRK_OK] = 1'b1;
		end
		if (ev.brk_err) begin
			next_st.irq_stat[IRQ_BRK_ERR] = 1'b1;
			// flag stays held in the device; re-enter break reception
			next_st.armed = 1'b0;
			if (st.ctrl[3] && st.running) begin
				next_st.arm_p = 1'b1;
			end
		end

		// sequencer
		unique case (st.fsm)
			ST_IDLE: begin
				// one quiet cycle after a device write before the next strobe
				if (st.bus.wr) begin
					next_st.fsm = ST_IDLE;
				end else if (st.rx_p) begin
					// error status first, buffer second
					next_st.rx_p     = ev.rx_done;
					next_st.bus.rd   = 1'b1;
					next_st.bus.addr = DEV_RXERR;
					next_st.wait_cnt = WAIT_CNT;
					next_st.ret      = ST_RXCK;
					next_st.fsm      = ST_RDWAIT;
				end else if (st.start_p) begin
					next_st.start_p   = 1'b0;
					next_st.bus.wr    = 1'b1;
					next_st.bus.addr  = DEV_MODE;
					next_st.bus.wdata = mode_byte | (8'h01 << MODE_POWER);
					next_st.fsm       = ST_PWR_ON;
				end else if (st.stop_p) begin
					next_st.bus.rd   = 1'b1;
					next_st.bus.addr = DEV_TXSTAT;
					next_st.wait_cnt = WAIT_CNT;
					next_st.ret      = ST_STOPCK;
					next_st.fsm      = ST_RDWAIT;
				end else if (st.cfg_p || st.arm_p) begin
					next_st.fsm = ST_EXT_WR;
				end else if (st.tx_full && st.running) begin
					next_st.bus.rd   = 1'b1;
					next_st.bus.addr = DEV_TXSTAT;
					next_st.wait_cnt = WAIT_CNT;
					next_st.ret      = ST_TXCK;
					next_st.fsm      = ST_RDWAIT;
				end
			end
			ST_PWR_ON: begin
				// power first, enables on a later write; device needs a gap between strobes
				if (!st.bus.wr) begin
					next_st.bus.wr    = 1'b1;
					next_st.bus.addr  = DEV_MODE;
					next_st.bus.wdata = mode_byte | (8'h01 << MODE_POWER)
						| (8'h01 << MODE_TXEN) | (8'h01 << MODE_RXEN);
					next_st.running   = 1'b1;
					next_st.fsm       = ST_IDLE;
				end
			end
			ST_EXT_WR: begin
				next_st.bus.wr    = 1'b1;
				next_st.bus.addr  = DEV_EXT;
				next_st.bus.wdata = ext_byte;
				// trigger only with power and receiver on
				if (st.arm_p && st.running) begin
					next_st.bus.wdata[EXT_TRIGGER] = 1'b1;
					next_st.armed = 1'b1;
				end
				next_st.arm_p = 1'b0;
				next_st.cfg_p = 1'b0;
				next_st.fsm   = ST_IDLE;
			end
			ST_RDWAIT: begin
				if (st.wait_cnt == 4'h0) begin
					next_st.fsm = st.ret;
				end else begin
					next_st.wait_cnt = st.wait_cnt - 4'h1;
				end
			end
			ST_RXCK: begin
				if (st.bus.addr == DEV_RXERR) begin
					next_st.rx_err   = st.rd_s2;
					next_st.bus.rd   = 1'b1;
					next_st.bus.addr = DEV_RXBUF;
					next_st.wait_cnt = WAIT_CNT;
					next_st.fsm      = ST_RDWAIT;
				end else begin
					next_st.rx_byte = st.rd_s2;
					next_st.irq_stat[IRQ_RX_BYTE] = 1'b1;
					if (st.rx_err != 8'h00) begin
						next_st.irq_stat[IRQ_RX_ERR] = 1'b1;
					end
					next_st.fsm = ST_IDLE;
				end
			end
			ST_TXCK: begin
				next_st.tx_stat = st.rd_s2;
				// LIN: whole status zero; else buffer-full alone decides
				if (lin ? (st.rd_s2 == 8'h00) : !st.rd_s2[TXS_FULL]) begin
					next_st.fsm = ST_EN_ON;
				end else begin
					next_st.fsm = ST_IDLE;
				end
			end
			ST_EN_ON: begin
				next_st.bus.wr    = 1'b1;
				next_st.bus.addr  = DEV_TXBUF;
				next_st.bus.wdata = st.tx_byte;
				next_st.tx_full   = 1'b0;
				next_st.n_sent    = st.n_sent + 16'h1;
				next_st.fsm       = ST_IDLE;
			end
			ST_STOPCK: begin
				next_st.tx_stat = st.rd_s2;
				// every frame completed and the shifter idle
				if ((st.n_sent == st.n_done) && !st.rd_s2[TXS_SHIFT]) begin
					next_st.fsm = ST_EN_OFF;
				end else begin
					next_st.fsm = ST_IDLE;
				end
			end
			ST_EN_OFF: begin
				next_st.bus.wr    = 1'b1;
				next_st.bus.addr  = DEV_MODE;
				next_st.bus.wdata = mode_byte | (8'h01 << MODE_POWER);
				next_st.fsm       = ST_PWROFF;
			end
			ST_PWROFF: begin
				// power drops only after the enables-off write has settled
				if (!st.bus.wr) begin
					next_st.bus.wr    = 1'b1;
					next_st.bus.addr  = DEV_MODE;
					next_st.bus.wdata = mode_byte;
					next_st.running   = 1'b0;
					next_st.armed     = 1'b0;
					next_st.stop_p    = 1'b0;
					next_st.arm_p     = 1'b0;
					next_st.fsm       = ST_IDLE;
				end
			end
			default: next_st.fsm = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st          <= '0;
			st.fsm      <= ST_IDLE;
			st.ret      <= ST_IDLE;
			st.ctrl     <= CTRL_RST;
			st.irq_mask <= MASK_RST;
		end else begin
			st <= next_st;
		end
	end

endmodule

`default_nettype wire

// ==== design/uslc_pkg.sv ====
package uslc_pkg;

	// device register indices on its own parallel port
	localparam logic [2:0] DEV_MODE     = 3'h0;
	localparam logic [2:0] DEV_EXT      = 3'h1;
	localparam logic [2:0] DEV_TXSTAT   = 3'h2;
	localparam logic [2:0] DEV_RXERR    = 3'h3;
	localparam logic [2:0] DEV_TXBUF    = 3'h4;
	localparam logic [2:0] DEV_RXBUF    = 3'h5;

	// bit positions inside device registers
	localparam int MODE_POWER   = 7;
	localparam int MODE_TXEN    = 6;
	localparam int MODE_RXEN    = 5;
	localparam int MODE_PAR_LO  = 3;
	localparam int EXT_TRIGGER  = 6;
	localparam int EXT_DIR      = 1;
	localparam int EXT_INVERT   = 0;
	localparam int TXS_FULL     = 1;
	localparam int TXS_SHIFT    = 0;

	// cycles from read strobe to device data at its pins
	localparam int DEV_RD_LAT   = 2;
	// two synchroniser stages follow the pins
	localparam int SYNC_STAGES  = 2;

	// own register word indices (haddr[4:2])
	localparam logic [2:0] REG_CTRL     = 3'h0;
	localparam logic [2:0] REG_CMD      = 3'h1;
	localparam logic [2:0] REG_TXDATA   = 3'h2;
	localparam logic [2:0] REG_STATUS   = 3'h3;
	localparam logic [2:0] REG_RXDATA   = 3'h4;
	localparam logic [2:0] REG_IRQ_STAT = 3'h5;
	localparam logic [2:0] REG_IRQ_MASK = 3'h6;
	localparam logic [2:0] REG_COUNT    = 3'h7;

	// command bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP  = 1;
	localparam int CMD_ARM   = 2;
	localparam int CMD_CFG   = 3;

	// irq bits
	localparam int IRQ_RX_BYTE = 0;
	localparam int IRQ_RX_ERR  = 1;
	localparam int IRQ_TX_DONE = 2;
	localparam int IRQ_BRK_OK  = 3;
	localparam int IRQ_BRK_ERR = 4;
	localparam int IRQ_REFUSED = 5;
	localparam int IRQ_TX_OVR  = 6;
	localparam int IRQ_W       = 7;

	// reset values
	localparam logic [5:0]       CTRL_RST = 6'h00;
	localparam logic [IRQ_W-1:0] MASK_RST = 7'h00;

	typedef enum logic [9:0] {
		ST_IDLE   = 10'h001,
		ST_PWR_ON = 10'h002,
		ST_EN_ON  = 10'h004,
		ST_EXT_WR = 10'h008,
		ST_RDWAIT = 10'h010,
		ST_STOPCK = 10'h020,
		ST_EN_OFF = 10'h040,
		ST_PWROFF = 10'h080,
		ST_TXCK   = 10'h100,
		ST_RXCK   = 10'h200
	} uslc_state_e;

	// device parallel port driven by the controller
	typedef struct packed {
		logic [2:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} uslc_dev_s;

	// event pins from the device
	typedef struct packed {
		logic tx_done;
		logic rx_done;
		logic brk_ok;
		logic brk_err;
	} uslc_evt_s;

	// register access from the bus slave
	typedef struct packed {
		logic        wr;
		logic [2:0]  wr_idx;
		logic [31:0] wdata;
		logic        rd;
		logic [2:0]  rd_idx;
	} uslc_req_s;

endpackage

// ==== design/uslc_ahb_slv.sv ====
`timescale 1ns/1ps
`default_nettype none

module uslc_ahb_slv (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	output uslc_pkg::uslc_req_s    req,
	input  wire logic [31:0]       rd_word
);
	import uslc_pkg::*;

	typedef struct packed {
		logic        wr_pend;
		logic [2:0]  wr_idx;
		logic [31:0] rdata;
	} uslc_slv_s;

	uslc_slv_s st;
	uslc_slv_s next_st;
	logic      accept;

	// nonseq or seq with the bus ready; zero wait state slave
	assign accept    = hsel & htrans[1] & hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = st.rdata;

	// reads take effect in the address phase, writes in the data phase
	always_comb begin
		req.wr     = st.wr_pend;
		req.wr_idx = st.wr_idx;
		req.wdata  = hwdata;
		req.rd     = accept & ~hwrite;
		req.rd_idx = haddr[4:2];
	end

	// hsize ignored: every access is treated as a word
	always_comb begin
		next_st         = st;
		next_st.wr_pend = accept & hwrite;
		next_st.wr_idx  = haddr[4:2];
		if (accept & ~hwrite) begin
			next_st.rdata = (haddr[31:5] == 27'h0) ? rd_word : 32'h0;
		end
		if (accept & hwrite & (haddr[31:5] != 27'h0)) begin
			next_st.wr_pend = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule

`default_nettype wire

// ==== bench/uslc_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// serial unit as seen at its parallel port, byte level only
module uslc_dev_model #(
	parameter int RD_LAT = uslc_pkg::DEV_RD_LAT,
	parameter int FRAME  = 30
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire uslc_pkg::uslc_dev_s dev,
	output logic [7:0]               dev_rdata,
	output uslc_pkg::uslc_evt_s      dev_evt,
	input  wire logic                rx_go,
	input  wire logic [7:0]          rx_byte,
	input  wire logic [7:0]          rx_err,
	input  wire logic                brk_go,
	input  wire logic                brk_bad
);
	import uslc_pkg::*;
	logic [7:0] mode, ext, rxbuf, rxerr, val, tcnt, busy_wr, lin_wr, last_tx;
	logic       full, shift, unread;
	logic [3:0] rcnt;
	logic [1:0] rxp, bop, bep;

	// register file, shifter and receiver
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{mode, ext, rxbuf, rxerr, val, tcnt, busy_wr, lin_wr, last_tx} <= '0;
			{full, shift, unread, rcnt, rxp, bop, bep} <= '0;
		end else begin
			if (rcnt != 4'h0) rcnt <= rcnt - 4'h1;
			if (rxp != 2'h0) rxp <= rxp - 2'h1;
			if (bop != 2'h0) bop <= bop - 2'h1;
			if (bep != 2'h0) bep <= bep - 2'h1;
			// buffer drops into the shifter: 10, then 01, then 11 on a second write
			if (full && !shift) begin
				shift <= 1'b1;
				full <= 1'b0;
				tcnt <= 8'(FRAME);
			end else if (shift) begin
				tcnt <= tcnt - 8'h1;
				if (tcnt == 8'h1) shift <= 1'b0;
			end
			if (dev.wr && dev.addr == DEV_MODE) mode <= dev.wdata;
			if (dev.wr && dev.addr == DEV_EXT) ext <= dev.wdata;
			if (dev.wr && dev.addr == DEV_TXBUF) begin
				full <= 1'b1;
				last_tx <= dev.wdata;
				if (full) busy_wr <= busy_wr + 8'h1;
				if (full || shift) lin_wr <= lin_wr + 8'h1;
			end
			if (dev.rd) begin
				rcnt <= 4'(RD_LAT + 4);
				case (dev.addr)
					DEV_MODE:   val <= mode;
					DEV_EXT:    val <= ext & 8'hbf;
					DEV_TXSTAT: val <= {6'h00, full, shift};
					DEV_RXERR:  val <= rxerr;
					DEV_RXBUF:  val <= rxbuf;
					default:    val <= 8'h00;
				endcase
			end
			if (dev.rd && dev.addr == DEV_RXBUF) unread <= 1'b0;
			if (dev.rd && dev.addr == DEV_RXBUF) rxerr <= 8'h00;
			// unread byte: new one is dropped, error sticks
			if (rx_go) begin
				rxp <= 2'h2;
				rxerr <= unread ? (rxerr | 8'h01) : rx_err;
				if (!unread) rxbuf <= rx_byte;
				unread <= 1'b1;
			end
			// any break ends the trigger, so a failed one needs re-arming
			if (brk_go && ext[EXT_TRIGGER]) begin
				ext[EXT_TRIGGER] <= 1'b0;
				if (brk_bad) bep <= 2'h2;
				else bop <= 2'h2;
			end
		end
	end

	assign dev_evt = {shift && tcnt <= 8'h2, rxp != 2'h0, bop != 2'h0, bep != 2'h0};
	// outside the hold window the pins show the inverse, so a late sample fails
	assign dev_rdata = (rcnt != 4'h0 && rcnt <= 4'(RD_LAT + 3)) ? val : ~val;
endmodule

`default_nettype wire

// ==== bench/uslc_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none

module uslc_ctrl_sva #(
	parameter int RD_LAT = uslc_pkg::DEV_RD_LAT
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire uslc_pkg::uslc_dev_s dev,
	input  wire logic [7:0]          dev_rdata,
	input  wire uslc_pkg::uslc_evt_s dev_evt
);
	import uslc_pkg::*;
	logic [7:0] mode_sh, ext_sh, cap;
	logic [2:0] last_rd;
	logic       mw, ew, tw, rb;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	assign mw = dev.wr && dev.addr == DEV_MODE;
	assign ew = dev.wr && dev.addr == DEV_EXT;
	assign tw = dev.wr && dev.addr == DEV_TXBUF;
	assign rb = dev.rd && dev.addr == DEV_RXBUF;

	// shadows of what the device was told and last answered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{mode_sh, ext_sh, cap, last_rd} <= '0;
		end else begin
			if (mw) mode_sh <= dev.wdata;
			if (ew) ext_sh <= dev.wdata & 8'hbf;
			if (dev.rd) last_rd <= dev.addr;
			// first cycle the answer is guaranteed
			if ($past(dev.rd, RD_LAT)) cap <= dev_rdata;
		end
	end

	a_strobe_spaced: assert property ((dev.wr || dev.rd) |=> !(dev.wr || dev.rd))
		else $error("device strobes too close");
	a_arm_when_on: assert property (ew && dev.wdata[EXT_TRIGGER] |-> mode_sh[MODE_POWER] && mode_sh[MODE_RXEN])
		else $error("break armed while unit off");
	a_order_locked: assert property (ew && dev.wdata[1:0] != ext_sh[1:0] |-> mode_sh[6:5] == 2'h0)
		else $error("bit order changed while enabled");
	a_power_first: assert property (mw && dev.wdata[6:5] != 2'h0
		|-> mode_sh[MODE_POWER] && dev.wdata[MODE_POWER]) else $error("enabled before power");
	a_power_last: assert property (mw && !dev.wdata[MODE_POWER]
		|-> mode_sh[6:5] == 2'h0 && dev.wdata[6:5] == 2'h0) else $error("power dropped before enables");
	a_room_checked: assert property (tw |-> last_rd == DEV_TXSTAT && !cap[TXS_FULL])
		else $error("byte written into a full buffer");
	a_idle_at_stop: assert property (mw && mode_sh[MODE_TXEN] && !dev.wdata[MODE_TXEN]
		|-> last_rd == DEV_TXSTAT && cap[1:0] == 2'h0) else $error("transmitter stopped while busy");
	a_error_first: assert property (rb |-> last_rd == DEV_RXERR)
		else $error("buffer read before error status");
	a_buffer_read: assert property ($rose(dev_evt.rx_done) |-> ##[1:200] rb)
		else $error("received byte never read");
endmodule

bind uslc_ctrl uslc_ctrl_sva #(.RD_LAT(RD_LAT)) u_sva (.hclk(hclk), .hresetn(hresetn), .dev(dev),
	.dev_rdata(dev_rdata), .dev_evt(dev_evt));

`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
	import uslc_pkg::*;
	typedef struct packed {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} uslc_row_s;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, rx_go, brk_go, brk_bad;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  dev_rdata, rx_byte, rx_err, lw;
	logic [31:0] haddr, hwdata, hrdata, q;
	uslc_dev_s   dev;
	uslc_evt_s   dev_evt;
	int          fail_count, comparisons;
	// reset values, mask access, unmapped write that leaves control untouched
	uslc_row_s   rows [7] = '{'{1'b0, 32'h00, 32'h0, 32'h0}, '{1'b0, 32'h18, 32'h0, 32'h0},
		'{1'b1, 32'h18, 32'h4, 32'h0}, '{1'b0, 32'h18, 32'h0, 32'h4}, '{1'b0, 32'h04, 32'h0, 32'h0},
		'{1'b1, 32'h20, 32'h3f, 32'h0}, '{1'b0, 32'h00, 32'h0, 32'h0}};

	uslc_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .irq(irq), .dev(dev), .dev_rdata(dev_rdata), .dev_evt(dev_evt));
	uslc_dev_model u_dev (.hclk(hclk), .hresetn(hresetn), .dev(dev), .dev_rdata(dev_rdata),
		.dev_evt(dev_evt), .rx_go(rx_go), .rx_byte(rx_byte), .rx_err(rx_err), .brk_go(brk_go),
		.brk_bad(brk_bad));

	always #20 hclk = ~hclk;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// one single word transfer, waiting on hready in both phases
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask

	task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
		q = ~v;
		for (int i = 0; i < 300 && (q & m) !== v; i++) ahb(1'b0, a, 32'h0, q);
		chk("poll", v, q & m);
	endtask

	task automatic pulse(input logic r, input logic b, input logic [7:0] d, input logic [7:0] e);
		@(posedge hclk);
		{rx_go, brk_go, brk_bad, rx_byte, rx_err} <= {r, !r, b, d, e};
		@(posedge hclk);
		{rx_go, brk_go} <= 2'h0;
	endtask

	task automatic final_report;
		if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// bounded run of 25000 cycles, far above the expected few hundred cycles
	initial begin
		#1000000;
		fail_count++;
		final_report();
	end

	initial begin
		{hclk, hresetn, hsel, hwrite, rx_go, brk_go, brk_bad, htrans, hsize, rx_byte, rx_err} = '0;
		{haddr, hwdata, q} = '0;
		hsize = 3'h2;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			ahb(rows[i].w, rows[i].a, rows[i].d, q);
			if (!rows[i].w) chk("row", rows[i].e, q);
		end
		// start with one parity bit set
		ahb(1'b1, 32'h00, 32'h10, q);
		ahb(1'b1, 32'h04, 32'h1, q);
		poll(32'h0c, 32'h3, 32'h2);
		chk("mode", 32'he8, {24'h0, u_dev.mode});
		// two bytes back to back, completion left unserviced
		ahb(1'b1, 32'h08, 32'h61, q);
		poll(32'h08, 32'h1, 32'h0);
		ahb(1'b1, 32'h08, 32'h62, q);
		poll(32'h1c, 32'hffffffff, 32'h00020002);
		chk("full_writes", 32'h0, {24'h0, u_dev.busy_wr});
		chk("last_tx", 32'h62, {24'h0, u_dev.last_tx});
		chk("irq", 32'h1, {31'h0, irq});
		ahb(1'b0, 32'h14, 32'h0, q);
		chk("irq_stat", 32'h44, q);
		@(negedge hclk);
		chk("irq", 32'h0, {31'h0, irq});
		// good then erroneous reception, masked off
		pulse(1'b1, 1'b0, 8'h5a, 8'h00);
		poll(32'h10, 32'hffff, 32'h005a);
		ahb(1'b0, 32'h10, 32'h0, q);
		chk("rx", 32'h005a, q);
		pulse(1'b1, 1'b0, 8'ha5, 8'h04);
		poll(32'h10, 32'hffff, 32'h04a5);
		ahb(1'b0, 32'h10, 32'h0, q);
		chk("rx", 32'h04a5, q);
		chk("irq", 32'h0, {31'h0, irq});
		ahb(1'b0, 32'h14, 32'h0, q);
		chk("irq_stat", 32'h03, q);
		// good break clears armed, failed break is re-armed
		ahb(1'b1, 32'h04, 32'h4, q);
		poll(32'h0c, 32'h5, 32'h4);
		pulse(1'b0, 1'b0, 8'h0, 8'h0);
		poll(32'h0c, 32'h4, 32'h0);
		ahb(1'b1, 32'h00, 32'h08, q);
		ahb(1'b1, 32'h04, 32'h4, q);
		poll(32'h0c, 32'h5, 32'h4);
		pulse(1'b0, 1'b1, 8'h0, 8'h0);
		poll(32'h14, 32'h10, 32'h10);
		for (int i = 0; i < 100 && u_dev.ext[EXT_TRIGGER] !== 1'b1; i++) @(posedge hclk);
		chk("rearm", 32'h1, {31'h0, u_dev.ext[EXT_TRIGGER]});
		// stop, refused byte, new bit order, then LIN start
		ahb(1'b1, 32'h04, 32'h2, q);
		poll(32'h0c, 32'h3, 32'h0);
		chk("mode", 32'h08, {24'h0, u_dev.mode});
		ahb(1'b1, 32'h08, 32'h55, q);
		ahb(1'b1, 32'h00, 32'h33, q);
		ahb(1'b1, 32'h04, 32'h8, q);
		poll(32'h0c, 32'h1, 32'h0);
		chk("ext", 32'h2, {30'h0, u_dev.ext[1:0]});
		ahb(1'b1, 32'h04, 32'h1, q);
		poll(32'h0c, 32'h3, 32'h2);
		chk("mode", 32'he0, {24'h0, u_dev.mode});
		lw = u_dev.lin_wr;
		ahb(1'b1, 32'h08, 32'h31, q);
		ahb(1'b1, 32'h08, 32'h32, q);
		poll(32'h08, 32'h1, 32'h0);
		ahb(1'b1, 32'h08, 32'h33, q);
		poll(32'h1c, 32'hffffffff, 32'h00040004);
		chk("busy_writes", {24'h0, lw}, {24'h0, u_dev.lin_wr});
		ahb(1'b0, 32'h14, 32'h0, q);
		chk("refused", 32'h20, q & 32'h20);
		// reset in mid-run
		hresetn <= 1'b0;
		@(negedge hclk);
		chk("dev", 32'h0, {19'h0, dev});
		chk("hready", 32'h1, {31'h0, hreadyout});
		chk("hresp", 32'h0, {31'h0, hresp});
		@(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, 32'h18, 32'h0, q);
		chk("mask", 32'h0, q);
		ahb(1'b0, 32'h0c, 32'h0, q);
		chk("status", 32'h0, q);
		final_report();
	end
endmodule

`default_nettype wire
